// >>> core/pdm_pkg.sv
/*
  constants for the controller data memory: register map, area sizes,
  field positions of the system bits, reset values.
  assumes a 32-bit avalon-mm slave with word-aligned byte addresses.
*/
package pdm_pkg;
  // address map: bits [17:16] area, [15:2] word index (byte addresses)
  localparam logic [1:0] PDM_AREA_BIT = 2'h0;   // bit areas, one bit per word
  localparam logic [1:0] PDM_AREA_WORD = 2'h1;  // small word areas
  localparam logic [1:0] PDM_AREA_RINT = 2'h2;  // internal word area
  localparam logic [1:0] PDM_AREA_CTRL = 2'h3;  // not decoded, reads zero
  // bit area sub-selects (index bits [12:10])
  localparam logic [2:0] PDM_SEL_IN = 3'h0;
  localparam logic [2:0] PDM_SEL_OUT = 3'h1;
  localparam logic [2:0] PDM_SEL_INT = 3'h2;
  localparam logic [2:0] PDM_SEL_SYS = 3'h3;
  // word area sub-selects (index bits [8:6])
  localparam logic [2:0] PDM_SEL_IW = 3'h0;
  localparam logic [2:0] PDM_SEL_OW = 3'h1;
  localparam logic [2:0] PDM_SEL_SW = 3'h2;
  localparam logic [2:0] PDM_SEL_XP = 3'h3;
  localparam logic [2:0] PDM_SEL_VAL = 3'h4;
  // area sizes
  localparam int PDM_N_IN = 128;
  localparam int PDM_N_OUT = 128;
  localparam int PDM_N_INT = 1024;
  localparam int PDM_N_SB = 64;
  localparam int PDM_N_IW = 64;
  localparam int PDM_N_OW = 64;
  localparam int PDM_N_SW = 64;
  localparam int PDM_N_XP = 4;
  localparam int PDM_N_RW = 8192;
  localparam int PDM_N_PHYS_IN = 24;
  localparam int PDM_N_PHYS_OUT = 16;
  localparam int PDM_N_PHYS_AW = 4;
  // system bit positions (1-based addresses kept as 0-based index)
  localparam int PDM_SB_PAUSE_A = 14;
  localparam int PDM_SB_PAUSE_B = 15;
  localparam int PDM_SB_CLR_A = 16;
  localparam int PDM_SB_CLR_B = 17;
  localparam int PDM_SB_MATCH1 = 18;
  localparam int PDM_SB_MATCH2 = 19;
  // system word positions of counter a and setpoints (0-based, low word first)
  localparam int PDM_SW_CNT_A = 26;
  localparam int PDM_SW_SP1 = 30;
  localparam int PDM_SW_SP2 = 32;
  // reset values
  localparam logic [15:0] PDM_WORD_RST = 16'h0000;
  localparam logic [31:0] PDM_RDATA_UNMAPPED = 32'h0000_0000;
  typedef enum logic [1:0] {PDM_IDLE, PDM_RWAIT, PDM_DONE} pdm_bus_state_t;
endpackage

// >>> core/pdm_word_ram.sv
/*
  internal word memory: 8192 words of 16 bits, one port, registered read.
  assumes the caller holds address steady while it waits for read data.
*/
`timescale 1ns/1ps
`default_nettype none
module pdm_word_ram
  import pdm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic we_i,
  input wire logic [12:0] addr_i,
  input wire logic [15:0] wdata_i,
  output var logic [15:0] rdata_o
);
  logic [15:0] mem [PDM_N_RW];

  // write and registered read
  always_ff @(posedge ref_clk_i)
  begin
    if (we_i)
    begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule
`default_nettype wire

// >>> core/pdm_data_memory.sv
/*
  typed data memory of a small programmable controller: bit and word areas,
  index/value pairs into the internal words, counter control system bits.
  assumes an avalon-mm master on ref_clk_i and synchronous pin inputs.
*/
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pdm_data_memory
  import pdm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [17:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output var logic [31:0] avs_readdata_o,
  output var logic avs_waitrequest_o,
  input wire logic [PDM_N_PHYS_IN-1:0] pin_in_i,
  output var logic [PDM_N_PHYS_OUT-1:0] pin_out_o,
  input wire logic [15:0] analog_in_i [PDM_N_PHYS_AW],
  output var logic [15:0] analog_out_o [PDM_N_PHYS_AW],
  input wire logic [31:0] counter_a_i,
  input wire logic [31:0] counter_b_i,
  output var logic pause_counter_a_o,
  output var logic pause_counter_b_o,
  output var logic clear_counter_a_o,
  output var logic clear_counter_b_o,
  output var logic isr_trigger_o
);
  ////////////////////////////////////////////////////////////////////////
  // storage
  logic [PDM_N_IN-1:0] in_bits;
  logic [PDM_N_OUT-1:0] out_bits;
  logic [PDM_N_INT-1:0] int_bits;
  logic [PDM_N_SB-1:0] system_bit;
  logic [15:0] input_word [PDM_N_IW];
  logic [15:0] out_word [PDM_N_OW];
  logic [15:0] system_word [PDM_N_SW];
  logic [15:0] index_pointer [PDM_N_XP];
  pdm_bus_state_t state;
  logic [31:0] rdata_hold;

  ////////////////////////////////////////////////////////////////////////
  // address decode
  wire [1:0] area = avs_address_i[17:16];
  wire [13:0] idx = avs_address_i[15:2];
  wire [2:0] bsel = idx[12:10];
  wire [9:0] bidx = idx[9:0];
  wire [2:0] wsel = idx[8:6];
  wire [5:0] widx = idx[5:0];
  wire [1:0] xidx = widx[1:0];
  wire is_bit = area == PDM_AREA_BIT;
  wire is_word = area == PDM_AREA_WORD;
  wire is_rint = area == PDM_AREA_RINT;
  // bit area hits, one bit per location
  wire hit_in = is_bit && bsel == PDM_SEL_IN && bidx < 10'(PDM_N_IN);
  wire hit_out = is_bit && bsel == PDM_SEL_OUT && bidx < 10'(PDM_N_OUT);
  wire hit_int = is_bit && bsel == PDM_SEL_INT;
  wire hit_sb = is_bit && bsel == PDM_SEL_SYS && bidx < 10'(PDM_N_SB);
  // word area hits, whole words only
  wire hit_iw = is_word && wsel == PDM_SEL_IW;
  wire hit_ow = is_word && wsel == PDM_SEL_OW;
  wire hit_sw = is_word && wsel == PDM_SEL_SW;
  wire hit_xp = is_word && wsel == PDM_SEL_XP && widx < 6'(PDM_N_XP);
  wire hit_val = is_word && wsel == PDM_SEL_VAL && widx < 6'(PDM_N_XP);
  wire hit_rint = is_rint && idx < 14'(PDM_N_RW);
  wire idle = state == PDM_IDLE;
  // writes land on the edge that takes the request
  wire wr = avs_write_i && idle;

  ////////////////////////////////////////////////////////////////////////
  // indirect access through the index pointers
  wire [15:0] ptr = index_pointer[xidx];
  wire ptr_ok = ptr >= 16'h0001 && ptr <= 16'(PDM_N_RW);
  wire [12:0] ptr_addr = 13'(ptr - 16'h0001);
  wire [12:0] ram_addr = hit_val ? ptr_addr : idx[12:0];
  wire ram_we = wr && (hit_rint || (hit_val && ptr_ok));
  wire ram_read = hit_rint || (hit_val && ptr_ok);
  logic [15:0] ram_rdata;

  // internal word ram, also reached through the value words
  pdm_word_ram u_ram (
    .ref_clk_i(ref_clk_i),
    .we_i(ram_we),
    .addr_i(ram_addr),
    .wdata_i(avs_writedata_i[15:0]),
    .rdata_o(ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // counter compares
  // live compares: flags drop again once counter a falls below
  wire signed [31:0] cnt_a = $signed({system_word[PDM_SW_CNT_A+1], system_word[PDM_SW_CNT_A]});
  wire signed [31:0] sp1 = $signed({system_word[PDM_SW_SP1+1], system_word[PDM_SW_SP1]});
  wire signed [31:0] sp2 = $signed({system_word[PDM_SW_SP2+1], system_word[PDM_SW_SP2]});
  wire next_match1 = cnt_a >= sp1;
  wire next_match2 = cnt_a >= sp2;

  ////////////////////////////////////////////////////////////////////////
  // combinational read mux for single-cycle areas; words zero-extended
  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = PDM_RDATA_UNMAPPED;
    if (hit_in)
      next_rdata = {31'h0, in_bits[bidx[6:0]]};
    else if (hit_out)
      next_rdata = {31'h0, out_bits[bidx[6:0]]};
    else if (hit_int)
      next_rdata = {31'h0, int_bits[bidx]};
    else if (hit_sb)
      next_rdata = {31'h0, system_bit[bidx[5:0]]};
    else if (hit_iw)
      next_rdata = {16'h0, input_word[widx]};
    else if (hit_ow)
      next_rdata = {16'h0, out_word[widx]};
    else if (hit_sw)
      next_rdata = {16'h0, system_word[widx]};
    else if (hit_xp)
      next_rdata = {16'h0, index_pointer[xidx]};
  end

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: two-cycle answer for everything, ram read data ready then
  // a request raised while busy waits for the idle state
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= PDM_IDLE;
      rdata_hold <= PDM_RDATA_UNMAPPED;
    end
    else
    begin
      case (state)
        PDM_IDLE:
          if (avs_read_i || avs_write_i)
          begin
            state <= PDM_RWAIT;
            rdata_hold <= next_rdata;
          end
        PDM_RWAIT: state <= PDM_DONE;
        PDM_DONE: state <= PDM_IDLE;
        default: state <= PDM_IDLE;
      endcase
    end
  end

  // read data register, loaded once per request
  wire [31:0] next_readdata = ram_read ? {16'h0, ram_rdata} : rdata_hold;
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= PDM_RDATA_UNMAPPED;
    end
    else
    begin
      avs_waitrequest_o <= state != PDM_RWAIT;
      avs_readdata_o <= (state == PDM_RWAIT) ? next_readdata : avs_readdata_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input bits and words sampled from pins, never written by the bus
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      in_bits <= '0;
    else
      in_bits <= {{(PDM_N_IN-PDM_N_PHYS_IN){1'b0}}, pin_in_i};
  end

  // input words 1-4 follow the analog inputs, the rest read zero
  generate
    for (genvar g = 0; g < PDM_N_IW; g++)
    begin : g_iw
      always_ff @(posedge ref_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          input_word[g] <= PDM_WORD_RST;
        else if (g < PDM_N_PHYS_AW)
          input_word[g] <= analog_in_i[g % PDM_N_PHYS_AW];
        else
          input_word[g] <= PDM_WORD_RST;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // writable bit areas; reset clears non-retained state only in simulation
  // sense: retention lives in the battery domain outside this block
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      out_bits <= '0;
      int_bits <= '0;
    end
    else if (wr)
    begin
      if (hit_out)
        out_bits[bidx[6:0]] <= avs_writedata_i[0];
      if (hit_int)
        int_bits[bidx] <= avs_writedata_i[0];
    end
  end

  // system bits: match flags follow the compare, others software-written
  generate
    for (genvar g = 0; g < PDM_N_SB; g++)
    begin : g_sb
      always_ff @(posedge ref_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          system_bit[g] <= 1'b0;
        else if (g == PDM_SB_MATCH1)
          system_bit[g] <= next_match1;
        else if (g == PDM_SB_MATCH2)
          system_bit[g] <= next_match2;
        else if (wr && hit_sb && bidx[5:0] == 6'(g))
          system_bit[g] <= avs_writedata_i[0];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // word areas; counter words are refreshed from the counters
  generate
    for (genvar g = 0; g < PDM_N_SW; g++)
    begin : g_sw
      // output words: scratch storage beyond the first four
      always_ff @(posedge ref_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          out_word[g] <= PDM_WORD_RST;
        else if (wr && hit_ow && widx == 6'(g))
          out_word[g] <= avs_writedata_i[15:0];
      end
      // system words: counter mirrors win over bus writes
      always_ff @(posedge ref_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          system_word[g] <= PDM_WORD_RST;
        else if (g == PDM_SW_CNT_A)
          system_word[g] <= counter_a_i[15:0];
        else if (g == PDM_SW_CNT_A + 1)
          system_word[g] <= counter_a_i[31:16];
        else if (g == PDM_SW_CNT_A + 2)
          system_word[g] <= counter_b_i[15:0];
        else if (g == PDM_SW_CNT_A + 3)
          system_word[g] <= counter_b_i[31:16];
        else if (wr && hit_sw && widx == 6'(g))
          system_word[g] <= avs_writedata_i[15:0];
      end
    end
  endgenerate

  // index pointers, taken whole from the bus
  generate
    for (genvar g = 0; g < PDM_N_XP; g++)
    begin : g_xp
      always_ff @(posedge ref_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          index_pointer[g] <= PDM_WORD_RST;
        else if (wr && hit_xp && xidx == 2'(g))
          index_pointer[g] <= avs_writedata_i[15:0];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // physical outputs and counter controls, all registered
  // match history for the rising-edge trigger
  logic match1_q;
  logic match2_q;
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_out_o <= '0;
      pause_counter_a_o <= 1'b0;
      pause_counter_b_o <= 1'b0;
      clear_counter_a_o <= 1'b0;
      clear_counter_b_o <= 1'b0;
      match1_q <= 1'b0;
      match2_q <= 1'b0;
      isr_trigger_o <= 1'b0;
    end
    else
    begin
      pin_out_o <= out_bits[PDM_N_PHYS_OUT-1:0];
      pause_counter_a_o <= system_bit[PDM_SB_PAUSE_A];
      pause_counter_b_o <= system_bit[PDM_SB_PAUSE_B];
      clear_counter_a_o <= system_bit[PDM_SB_CLR_A];
      clear_counter_b_o <= system_bit[PDM_SB_CLR_B];
      match1_q <= system_bit[PDM_SB_MATCH1];
      match2_q <= system_bit[PDM_SB_MATCH2];
      isr_trigger_o <= (system_bit[PDM_SB_MATCH1] && !match1_q)
                    || (system_bit[PDM_SB_MATCH2] && !match2_q);
    end
  end

  // analog outputs follow output words 1-4
  generate
    for (genvar g = 0; g < PDM_N_PHYS_AW; g++)
    begin : g_ao
      always_ff @(posedge ref_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          analog_out_o[g] <= PDM_WORD_RST;
        else
          analog_out_o[g] <= out_word[g];
      end
    end
  endgenerate
endmodule
`default_nettype wire

// >>> tb/pdm_field_model.sv
/*
  field side model: physical input pins, analog inputs and two counters
  that follow the pause and clear levels of the data memory.
  assumes one clock shared with the data memory.
*/
`timescale 1ns/1ps
`default_nettype none
module pdm_field_model
  import pdm_pkg::*;
#(
  parameter logic [23:0] PIN_PAT = 24'h8a5c31,
  parameter logic [15:0] ANA_BASE = 16'h1200
)
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic pause_a_i,
  input wire logic pause_b_i,
  input wire logic clear_a_i,
  input wire logic clear_b_i,
  output var logic [23:0] pin_in_o,
  output var logic [15:0] analog_in_o [PDM_N_PHYS_AW],
  output var logic [31:0] counter_a_o,
  output var logic [31:0] counter_b_o
);
  // fixed pin and analog patterns
  assign pin_in_o = PIN_PAT;
  always_comb
  begin
    for (int i = 0; i < PDM_N_PHYS_AW; i++)
      analog_in_o[i] = ANA_BASE + 16'(i);
  end

  // counters: clear wins over pause, else count up
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      counter_a_o <= 32'h0;
      counter_b_o <= 32'h0;
    end
    else
    begin
      counter_a_o <= clear_a_i ? 32'h0 : counter_a_o + {31'h0, !pause_a_i};
      counter_b_o <= clear_b_i ? 32'h0 : counter_b_o + {31'h0, !pause_b_i};
    end
  end
endmodule
`default_nettype wire

// >>> tb/pdm_data_memory_monitor.sv
/*
  bus timing and output checks for the data memory.
  assumes the fixed two-cycle answer of the register bus.
*/
`timescale 1ns/1ps
`default_nettype none
module pdm_data_memory_monitor
  import pdm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [17:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [15:0] pin_out_o,
  input wire logic [15:0] analog_out_o [PDM_N_PHYS_AW],
  input wire logic pause_counter_a_o,
  input wire logic pause_counter_b_o,
  input wire logic clear_counter_a_o,
  input wire logic clear_counter_b_o,
  input wire logic isr_trigger_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  ////////////////////////////////////////////////////////////////////////////
  // decode of the request under way
  wire logic [9:0] bit_idx = avs_address_i[11:2];
  wire logic bit_area = avs_address_i[17:16] == PDM_AREA_BIT && !avs_address_i[15];
  wire logic out_wr = bit_area && avs_address_i[14:12] == PDM_SEL_OUT && bit_idx < 10'h10;
  wire logic sys_wr = bit_area && avs_address_i[14:12] == PDM_SEL_SYS && bit_idx >= 10'he
    && bit_idx <= 10'h11;
  wire logic ow_wr = avs_address_i[17:16] == PDM_AREA_WORD && avs_address_i[15:4] == 12'h010;
  wire logic [3:0] ctl = {clear_counter_b_o, clear_counter_a_o, pause_counter_b_o,
    pause_counter_a_o};
  wire logic ans = !avs_waitrequest_o;

  ////////////////////////////////////////////////////////////////////////////
  // two busy cycles, then the answer
  sequence s_answer;
    avs_waitrequest_o ##1 avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence

  a_read_answer: assert property ($rose(avs_read_i) |-> s_answer)
    else $error("read answer timing wrong");
  a_write_answer: assert property ($rose(avs_write_i) |-> s_answer)
    else $error("write answer timing wrong");
  a_wait_single: assert property (ans |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_answer_cause: assert property ($fell(avs_waitrequest_o) |->
    $past(avs_read_i || avs_write_i, 2))
    else $error("answer without request");
  a_read_upper: assert property (ans && avs_read_i |-> avs_readdata_o[31:16] == 16'h0)
    else $error("read data upper half not zero");
  a_bit_single: assert property (ans && avs_read_i && bit_area |->
    avs_readdata_o[31:1] == 31'h0)
    else $error("bit read wider than one bit");
  a_out_pin: assert property (ans && avs_write_i && out_wr |->
    pin_out_o[bit_idx[3:0]] == avs_writedata_i[0])
    else $error("output pin does not follow bit");
  a_analog_out: assert property (ans && avs_write_i && ow_wr |->
    analog_out_o[avs_address_i[3:2]] == avs_writedata_i[15:0])
    else $error("analog output does not follow word");
  a_ctl_copy: assert property (ans && avs_write_i && sys_wr |->
    ctl[bit_idx[1:0] - 2'h2] == avs_writedata_i[0])
    else $error("counter control level wrong");
  a_isr_pulse: assert property (isr_trigger_o |=> !isr_trigger_o)
    else $error("trigger longer than one cycle");
endmodule

bind pdm_data_memory pdm_data_memory_monitor u_monitor (
  .ref_clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_readdata_o, .avs_waitrequest_o, .pin_out_o, .analog_out_o, .pause_counter_a_o,
  .pause_counter_b_o, .clear_counter_a_o, .clear_counter_b_o, .isr_trigger_o
);
`default_nettype wire

// >>> tb/pdm_data_memory_test.sv
/*
  self-checking bench for the data memory: avalon reads and writes
  through every area, index pointers, counter compare and trigger.
  assumes the field model drives pins, analog words and counters.
*/
`timescale 1ns/1ps
`default_nettype none
module pdm_data_memory_test
  import pdm_pkg::*;
;
  localparam logic [23:0] PIN = 24'h8a5c31;
  localparam logic [15:0] ANA = 16'h1200;
  logic ref_clk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, isr_trigger_o;
  logic [17:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, counter_a_i, counter_b_i;
  logic [23:0] pin_in_i;
  logic [15:0] pin_out_o;
  logic [15:0] analog_in_i [PDM_N_PHYS_AW];
  logic [15:0] analog_out_o [PDM_N_PHYS_AW];
  wire logic [3:0] ctl;
  int err_count = 0;
  int check_count = 0;
  int isr_n = 0;
  int n;

  ////////////////////////////////////////////////////////////////////////////
  // device and field side
  pdm_data_memory DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
    .analog_in_i(analog_in_i), .analog_out_o(analog_out_o), .counter_a_i(counter_a_i),
    .counter_b_i(counter_b_i), .pause_counter_a_o(ctl[0]), .pause_counter_b_o(ctl[1]),
    .clear_counter_a_o(ctl[2]), .clear_counter_b_o(ctl[3]), .isr_trigger_o(isr_trigger_o));
  pdm_field_model #(.PIN_PAT(PIN), .ANA_BASE(ANA)) u_field (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .pause_a_i(ctl[0]), .pause_b_i(ctl[1]), .clear_a_i(ctl[2]),
    .clear_b_i(ctl[3]), .pin_in_o(pin_in_i), .analog_in_o(analog_in_i),
    .counter_a_o(counter_a_i), .counter_b_o(counter_b_i));

  ////////////////////////////////////////////////////////////////////////////
  // clock, trigger count, watchdog
  always #4 ref_clk_i = !ref_clk_i;
  always @(posedge ref_clk_i) if (isr_trigger_o === 1'b1) isr_n <= isr_n + 1;
  initial
  begin
    repeat (5000) @(posedge ref_clk_i);
    err_count++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // addresses and bus tasks
  function automatic logic [17:0] ba(input logic [2:0] s, input int a);
    return {PDM_AREA_BIT, 1'b0, s, 10'(a - 1), 2'h0};
  endfunction
  function automatic logic [17:0] wa(input logic [2:0] s, input int a);
    return {PDM_AREA_WORD, 5'h0, s, 6'(a - 1), 2'h0};
  endfunction
  function automatic logic [17:0] ra(input int a);
    return {PDM_AREA_RINT, 1'b0, 13'(a - 1), 2'h0};
  endfunction
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [17:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !w;
    avs_write_i <= w;
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [17:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial
  begin
    ref_clk_i = 1'b0;
    rst_n_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 18'h0;
    avs_writedata_i = 32'h0;
    repeat (6) @(posedge ref_clk_i);
    chk({avs_waitrequest_o, isr_trigger_o, ctl, pin_out_o}, 32'h200000);
    rst_n_i <= 1'b1;
    $display("test reset done");
    rd(ba(PDM_SEL_IN, 1), {31'h0, PIN[0]});
    rd(ba(PDM_SEL_IN, 24), {31'h0, PIN[23]});
    rd(ba(PDM_SEL_IN, 2), {31'h0, PIN[1]});
    rd(ba(PDM_SEL_IN, 25), 32'h0);
    rd({PDM_AREA_CTRL, 16'h0}, 32'h0);
    wr(ba(PDM_SEL_IN, 1), 32'h0);
    rd(ba(PDM_SEL_IN, 1), {31'h0, PIN[0]});
    wr(ba(PDM_SEL_OUT, 1), 32'h1);
    wr(ba(PDM_SEL_OUT, 16), 32'hffff_ffff);
    wr(ba(PDM_SEL_OUT, 17), 32'h1);
    wr(ba(PDM_SEL_OUT, 2), 32'hffff_fffe);
    chk({16'h0, pin_out_o}, 32'h8001);
    rd(ba(PDM_SEL_OUT, 17), 32'h1);
    rd(ba(PDM_SEL_OUT, 2), 32'h0);
    wr(ba(PDM_SEL_INT, 1024), 32'h1);
    rd(ba(PDM_SEL_INT, 1024), 32'h1);
    rd(ba(PDM_SEL_INT, 1023), 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(ba(PDM_SEL_SYS, 15 + i), 32'h1);
      chk({28'h0, ctl}, 32'h1 << i);
      wr(ba(PDM_SEL_SYS, 15 + i), 32'h0);
    end
    $display("test bits done");
    for (int i = 0; i < 4; i++)
      rd(wa(PDM_SEL_IW, i + 1), {16'h0, ANA + 16'(i)});
    wr(wa(PDM_SEL_IW, 1), 32'h5555);
    rd(wa(PDM_SEL_IW, 1), {16'h0, ANA});
    wr(wa(PDM_SEL_OW, 1), 32'habcd);
    wr(wa(PDM_SEL_OW, 4), 32'h1234);
    wr(wa(PDM_SEL_OW, 64), 32'hbeef);
    chk({analog_out_o[0], analog_out_o[3]}, 32'habcd_1234);
    rd(wa(PDM_SEL_OW, 64), 32'hbeef);
    rd(wa(PDM_SEL_OW, 1), 32'habcd);
    wr(wa(PDM_SEL_SW, 64), 32'h1_c0de);
    rd(wa(PDM_SEL_SW, 64), 32'hc0de);
    wr(ra(1), 32'h7777);
    wr(ra(8192), 32'h8888);
    rd(ra(1), 32'h7777);
    rd(ra(8192), 32'h8888);
    $display("test words done");
    wr(ra(59), 32'h2692);
    wr(wa(PDM_SEL_XP, 1), 32'h3b);
    rd(wa(PDM_SEL_XP, 1), 32'h3b);
    rd(wa(PDM_SEL_VAL, 1), 32'h2692);
    wr(wa(PDM_SEL_XP, 2), 32'h1f40);
    wr(wa(PDM_SEL_VAL, 2), 32'h20);
    rd(ra(8000), 32'h20);
    wr(wa(PDM_SEL_XP, 3), 32'h0);
    wr(wa(PDM_SEL_VAL, 3), 32'h55);
    rd(wa(PDM_SEL_VAL, 3), 32'h0);
    wr(wa(PDM_SEL_XP, 4), 32'h2001);
    wr(wa(PDM_SEL_VAL, 4), 32'h66);
    rd(wa(PDM_SEL_VAL, 4), 32'h0);
    rd(ra(1), 32'h7777);
    rd(ra(8192), 32'h8888);
    $display("test index done");
    wr(ba(PDM_SEL_SYS, 15), 32'h1);
    wr(ba(PDM_SEL_SYS, 17), 32'h1);
    wr(ba(PDM_SEL_SYS, 17), 32'h0);
    wr(wa(PDM_SEL_SW, 31), 32'h28);
    rd(ba(PDM_SEL_SYS, 19), 32'h0);
    wr(wa(PDM_SEL_SW, 33), 32'hfffb);
    wr(wa(PDM_SEL_SW, 34), 32'hffff);
    rd(ba(PDM_SEL_SYS, 20), 32'h1);
    rd(wa(PDM_SEL_SW, 27), 32'h0);
    n = isr_n;
    wr(ba(PDM_SEL_SYS, 15), 32'h0);
    for (int i = 0; i < 200 && isr_n == n; i++) @(posedge ref_clk_i);
    chk(isr_n - n, 32'h1);
    rd(ba(PDM_SEL_SYS, 19), 32'h1);
    wr(wa(PDM_SEL_SW, 32), 32'h7fff);
    rd(ba(PDM_SEL_SYS, 19), 32'h0);
    wr(ba(PDM_SEL_SYS, 15), 32'h1);
    rd(wa(PDM_SEL_SW, 27), {16'h0, counter_a_i[15:0]});
    rd(wa(PDM_SEL_SW, 28), {16'h0, counter_a_i[31:16]});
    $display("test counter done");
    stop_test();
  end
endmodule
`default_nettype wire
